// File: src/cbsc_map.svh
// constants for the processor bus signal control block
`ifndef CBSC_MAP_SVH
`define CBSC_MAP_SVH
`define CBSC_CLK_NS        10
`define CBSC_E_PERIOD      10
`define CBSC_E_LOW         6
`define CBSC_MODE_HOLD     2
`define CBSC_ADDR_W        23
`define CBSC_DATA_W        16
`define CBSC_IACK_ADDR_HI  20'hFFFFF
`define CBSC_SPACE_CPU     3'h7
`define CBSC_FAULT_LIMIT   2'h2
`endif

// File: src/cbsc_pkg.sv
// types for the processor bus signal control block
package cbsc_pkg;
  typedef enum logic [2:0] {
    CB_IDLE  = 3'h0,
    CB_ADDR  = 3'h1,
    CB_WAIT  = 3'h3,
    CB_SYNC  = 3'h2,
    CB_DONE  = 3'h6,
    CB_HALT  = 3'h4,
    CB_OFF   = 3'h5
  } cbsc_state_e;

  // request from the core to the bus sequencer
  typedef struct packed {
    logic        valid;
    logic        read;
    logic        iack;
    logic        upper;
    logic        lower;
    logic [2:0]  space;
    logic [22:0] addr;
    logic [15:0] wdata;
  } cbsc_req_s;

  // answer back to the core
  typedef struct packed {
    logic        done;
    logic        fault;
    logic        retry;
    logic        autovec;
    logic [15:0] rdata;
  } cbsc_rsp_s;

  // synchronised bus inputs
  typedef struct packed {
    logic ack_n;
    logic fault_n;
    logic periph_n;
    logic req_n;
    logic gack_n;
    logic halt_n;
    logic reset_n;
  } cbsc_in_s;
endpackage : cbsc_pkg

// File: src/cbsc_sync.sv
// two-flop synchroniser for a group of bus inputs
`timescale 1ns/1ps
`default_nettype none
module cbsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cbsc_sync_s;
  cbsc_sync_s st;
  cbsc_sync_s next_st;

  // first stage feeds only the second
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // register both stages; first stage keeps tracking the pin in reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{s1: d, s2: INIT};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule : cbsc_sync
`default_nettype wire

// File: src/cbsc_eclk.sv
// ring divider making the slow peripheral clock
`timescale 1ns/1ps
`default_nettype none
`include "cbsc_map.svh"
module cbsc_eclk (
  input  wire logic clk,
  output var  logic e_clk,
  output var  logic e_fall
);
  typedef struct packed {
    logic [9:0] ring;
  } cbsc_eclk_s;
  cbsc_eclk_s st;
  cbsc_eclk_s next_st;

  // one-hot ring; any other pattern, powerup junk too, heals to slot zero
  always_comb begin
    next_st = st;
    if (st.ring != 10'h000 && (st.ring & (st.ring - 10'h001)) == 10'h000) begin
      next_st.ring = {st.ring[8:0], st.ring[9]};
    end else begin
      next_st.ring = 10'h001;
    end
  end

  // ring not reset
  // no reset: phase against the core clock is undefined
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // high for the last four slots, low for the first six
  assign e_clk  = |st.ring[9:`CBSC_E_LOW];
  assign e_fall = st.ring[9];
endmodule : cbsc_eclk
`default_nettype wire

// File: src/cbsc_top.sv
// processor-side bus cycle, arbitration and system control
`timescale 1ns/1ps
`default_nettype none
`include "cbsc_map.svh"
module cbsc_top
  import cbsc_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // core side
  input  wire cbsc_req_s   REQ,
  output var  cbsc_rsp_s   RSP,
  input  wire logic        RESET_CMD,
  input  wire logic        STOPPED,
  input  wire logic        NARROW_PART,
  input  wire logic        REDUCED_IRQ,
  output var  logic [2:0]  IRQ_LEVEL,
  output var  logic        IRQ_NMI,
  output var  logic        SYS_RESET,
  output var  logic        WIDE_BUS,
  // address and control outputs
  output var  logic [22:0] ADDR,
  output var  logic [2:0]  SPACE_CODE,
  output var  logic        ADDR_STROBE_N,
  output var  logic        UPPER_BYTE_STROBE_N,
  output var  logic        LOWER_BYTE_STROBE_N,
  output var  logic        READ_NOT_WRITE,
  output var  logic        BUS_OE,
  // data bus
  input  wire logic [15:0] DATA_I,
  output var  logic [15:0] DATA_O,
  output var  logic        DATA_OE,
  // handshakes, arbitration, interrupt priority and width select
  input  wire logic        XFER_ACK_N,
  input  wire logic        BUS_FAULT_N,
  input  wire logic        BUS_REQUEST_N,
  output var  logic        BUS_GRANT_N,
  input  wire logic        GRANT_ACK_N,
  input  wire logic [2:0]  IRQ_PRIORITY_IN,
  input  wire logic        WIDTH_SEL,
  // open-drain reset and halt
  input  wire logic        RESET_I,
  output var  logic        RESET_O,
  output var  logic        RESET_OE,
  input  wire logic        HALT_I,
  output var  logic        HALT_O,
  output var  logic        HALT_OE,
  // slow peripheral port
  output var  logic        SLOW_BUS_CLK,
  input  wire logic        SYNC_PERIPH_SELECT_N,
  output var  logic        SYNC_ADDR_VALID_N
);
  typedef struct packed {
    cbsc_state_e  state;
    cbsc_req_s    cur;
    logic [15:0]  rdata;
    logic         done;
    logic         fault;
    logic         retry;
    logic         autovec;
    logic         as;
    logic         sync_addr_valid_n;
    logic         granted;
    logic         wide;
    logic [1:0]   mode_cnt;
    logic [2:0]   irq;
    logic         rst_drive;
    logic [1:0]   rst_tail;
  } cbsc_top_s;
  cbsc_top_s st;
  cbsc_top_s next_st;

  cbsc_in_s    sin;
  logic [2:0]  irq_s;
  logic        width_s;
  logic        e_fall;
  logic        bus_busy;
  logic        halt_in;
  logic [2:0]  irq_dec;

  cbsc_sync #(.W(7), .INIT(7'h7F)) u_sync_ctl (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     ({XFER_ACK_N, BUS_FAULT_N, SYNC_PERIPH_SELECT_N, BUS_REQUEST_N,
             GRANT_ACK_N, HALT_I, RESET_I}),
    .q     (sin)
  );
  cbsc_sync #(.W(4), .INIT(4'hF)) u_sync_lvl (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     ({IRQ_PRIORITY_IN, WIDTH_SEL}),
    .q     ({irq_s, width_s})
  );

  cbsc_eclk u_eclk (
    .clk    (MCLK),
    .e_clk  (SLOW_BUS_CLK),
    .e_fall (e_fall)
  );

  // shared bit0/bit2 pin on reduced part
  always_comb begin
    irq_dec = ~irq_s;
    if (REDUCED_IRQ) begin
      irq_dec[2] = irq_dec[0];
    end
  end

  // own reset drive and its synchroniser echo mask the halt pin
  assign halt_in  = !sin.halt_n && !st.rst_drive && st.rst_tail == 2'h0;
  assign bus_busy = st.state != CB_IDLE && st.state != CB_OFF && st.state != CB_HALT;

  // main sequencer
  always_comb begin
    next_st         = st;
    next_st.done    = 1'b0;
    next_st.fault   = 1'b0;
    next_st.retry   = 1'b0;
    next_st.autovec = 1'b0;
    next_st.irq     = irq_dec;
    // width caught two clocks after reset release
    if (st.mode_cnt != `CBSC_MODE_HOLD) begin
      next_st.mode_cnt = st.mode_cnt + 2'h1;
      next_st.wide     = width_s;
    end
    // reset line driven while core asks
    next_st.rst_drive = RESET_CMD;
    next_st.rst_tail  = {st.rst_tail[0], st.rst_drive};
    unique case (st.state)
      CB_IDLE: begin
        if (!sin.req_n) begin
          next_st.granted = 1'b1;
          next_st.state   = CB_OFF;
        end else if (halt_in) begin
          next_st.state = CB_HALT;
        end else if (REQ.valid) begin
          next_st.cur   = REQ;
          next_st.state = CB_ADDR;
        end
      end
      CB_ADDR: begin
        next_st.as    = 1'b1;
        next_st.state = CB_WAIT;
      end
      CB_WAIT: begin
        // mid-cycle request: grant now, release later
        if (!sin.req_n) begin
          next_st.granted = 1'b1;
        end
        // fault: retry when halt also asserted
        if (!sin.fault_n) begin
          next_st.fault = sin.halt_n;
          next_st.retry = !sin.halt_n;
          next_st.as    = 1'b0;
          next_st.state = CB_DONE;
        end else if (!sin.periph_n) begin
          if (st.cur.iack) begin
            next_st.autovec = 1'b1;
            next_st.as      = 1'b0;
            next_st.state   = CB_DONE;
          end else begin
            next_st.state = CB_SYNC;
          end
        end else if (!sin.ack_n) begin
          // latch data on read, end cycle
          if (st.cur.read) begin
            next_st.rdata = DATA_I;
          end
          next_st.done  = 1'b1;
          next_st.as    = 1'b0;
          next_st.state = CB_DONE;
        end
      end
      CB_SYNC: begin
        if (e_fall && !st.sync_addr_valid_n) begin
          next_st.sync_addr_valid_n = 1'b1;
        end else if (e_fall && st.sync_addr_valid_n) begin
          if (st.cur.read) begin
            next_st.rdata = DATA_I;
          end
          next_st.done  = 1'b1;
          next_st.sync_addr_valid_n   = 1'b0;
          next_st.as    = 1'b0;
          next_st.state = CB_DONE;
        end
      end
      CB_DONE: begin
        if (st.granted) begin
          next_st.state = CB_OFF;
        end else if (halt_in) begin
          next_st.state = CB_HALT;
        end else begin
          next_st.state = CB_IDLE;
        end
      end
      CB_HALT: begin
        if (!halt_in) begin
          next_st.state = CB_IDLE;
        end
      end
      CB_OFF: begin
        // hold off while request or acknowledge stand
        if (sin.req_n) begin
          next_st.granted = 1'b0;
        end
        if (sin.req_n && sin.gack_n) begin
          next_st.state = CB_IDLE;
        end
      end
      default: begin
        next_st.state = CB_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign WIDE_BUS = st.wide && !NARROW_PART;

  // drive address group only while owning an active cycle
  assign BUS_OE = bus_busy;

  // acknowledge address: level on A3-A1, upper ones high
  always_comb begin
    if (st.cur.iack) begin
      ADDR = {`CBSC_IACK_ADDR_HI, st.cur.addr[2:0]};
    end else begin
      ADDR = st.cur.addr;
    end
  end
  assign SPACE_CODE = st.cur.iack ? `CBSC_SPACE_CPU : st.cur.space;

  assign ADDR_STROBE_N  = !st.as;
  assign READ_NOT_WRITE = st.cur.read || !st.as;

  assign UPPER_BYTE_STROBE_N = !(st.as && st.cur.upper && WIDE_BUS);
  assign LOWER_BYTE_STROBE_N = !(st.as && (st.cur.lower || (!WIDE_BUS && st.cur.upper)));

  // write data, single byte copied to the other lane
  always_comb begin
    DATA_O = st.cur.wdata;
    if (st.cur.upper && !st.cur.lower) begin
      DATA_O[7:0] = st.cur.wdata[15:8];
    end else if (st.cur.lower && !st.cur.upper) begin
      DATA_O[15:8] = st.cur.wdata[7:0];
    end
  end
  assign DATA_OE = st.as && !st.cur.read;

  assign BUS_GRANT_N = !st.granted;

  assign SYNC_ADDR_VALID_N = !st.sync_addr_valid_n;

  assign IRQ_LEVEL = st.irq;
  assign IRQ_NMI   = st.irq == 3'h7;

  // external reset with halt resets the system
  assign SYS_RESET = !sin.reset_n && !sin.halt_n && !st.rst_drive && st.rst_tail == 2'h0;

  assign RESET_O  = 1'b0;
  assign RESET_OE = st.rst_drive;
  assign HALT_O   = 1'b0;
  assign HALT_OE  = STOPPED;

  // core answers
  assign RSP = '{done: st.done, fault: st.fault, retry: st.retry,
                 autovec: st.autovec, rdata: st.rdata};
endmodule : cbsc_top
`default_nettype wire

// File: testbench/cbsc_top_props.sv
// checker for the bus signal control block
`timescale 1ns/1ps
`default_nettype none
module cbsc_top_props
  import cbsc_pkg::*;
(
  // watched ports
  input wire logic        MCLK, RST_N, ADDR_STROBE_N, UPPER_BYTE_STROBE_N, LOWER_BYTE_STROBE_N,
  input wire logic        READ_NOT_WRITE, BUS_OE, DATA_OE, WIDE_BUS, SLOW_BUS_CLK, XFER_ACK_N,
  input wire logic        SYNC_ADDR_VALID_N, SYNC_PERIPH_SELECT_N, RESET_CMD, RESET_OE, STOPPED, HALT_OE,
  input wire logic [2:0]  SPACE_CODE,
  input wire logic [22:0] ADDR,
  input wire logic [15:0] DATA_O,
  input wire cbsc_rsp_s   RSP
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_dir; DATA_OE |-> !READ_NOT_WRITE; endproperty
  a_dir: assert property (p_dir) else $error("data driven during read");
  property p_narrow; !WIDE_BUS |-> UPPER_BYTE_STROBE_N; endproperty
  a_narrow: assert property (p_narrow) else $error("upper strobe in narrow mode");
  property p_lower; !WIDE_BUS && !ADDR_STROBE_N |-> !LOWER_BYTE_STROBE_N; endproperty
  a_lower: assert property (p_lower) else $error("narrow cycle without lower strobe");
  property p_dup; WIDE_BUS && DATA_OE && (UPPER_BYTE_STROBE_N != LOWER_BYTE_STROBE_N) |-> DATA_O[15:8] == DATA_O[7:0];
  endproperty
  a_dup: assert property (p_dup) else $error("byte write not copied");
  property p_ack; $fell(XFER_ACK_N) && !ADDR_STROBE_N |-> ##[1:5] RSP.done; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not end cycle");
  property p_float; !BUS_OE |-> ADDR_STROBE_N && UPPER_BYTE_STROBE_N && LOWER_BYTE_STROBE_N && !DATA_OE; endproperty
  a_float: assert property (p_float) else $error("control active while bus released");
  property p_eclk; $rose(SLOW_BUS_CLK) |-> SLOW_BUS_CLK[*4] ##1 !SLOW_BUS_CLK[*6] ##1 SLOW_BUS_CLK; endproperty
  a_eclk: assert property (p_eclk) else $error("slow clock shape wrong");
  property p_vma; $fell(SYNC_ADDR_VALID_N) |-> !SYNC_PERIPH_SELECT_N && !ADDR_STROBE_N; endproperty
  a_vma: assert property (p_vma) else $error("sync valid without select");
  property p_iack; !ADDR_STROBE_N && SPACE_CODE == 3'h7 |-> &ADDR[22:3]; endproperty
  a_iack: assert property (p_iack) else $error("acknowledge address not high");
  property p_sys; RESET_CMD && STOPPED |-> ##[0:2] RESET_OE && HALT_OE; endproperty
  a_sys: assert property (p_sys) else $error("reset or halt line not driven");
  // main scenarios
  c_done: cover property (RSP.done);
  c_auto: cover property (RSP.autovec);
  c_retry: cover property (RSP.retry);
  c_vma: cover property (!SYNC_ADDR_VALID_N);
endmodule : cbsc_top_props
`default_nettype wire

// File: testbench/cbsc_far.sv
// far-side memory and peripheral model
`timescale 1ns/1ps
`default_nettype none
module cbsc_far (
  // bus from the block
  input  wire logic        clk,
  input  wire logic        astb_n,
  input  wire logic [2:0]  space,
  input  wire logic [22:0] addr,
  // answers
  output var  logic        ack_n = 1'b1,
  output var  logic        flt_n = 1'b1,
  output var  logic        sel_n = 1'b1,
  output var  logic [15:0] dat = 16'h0000
);
  logic [2:0] cnt = 3'h0;
  logic       fin = 1'b0;
  // answer after a wait set by the low address bits
  always @(posedge clk) begin
    #1;
    if (astb_n) begin
      cnt = 3'h0;
      fin = 1'b0;
      ack_n = 1'b1;
      flt_n = 1'b1;
      sel_n = 1'b1;
      dat = ~dat; // no stale data
    end else if (!fin) begin
      dat = ~dat;
      if (cnt == addr[2:0]) begin
        fin = 1'b1;
        dat = addr[15:0] ^ 16'h5A5A;
        if (space == 3'h7 || addr[22]) sel_n = 1'b0;
        else if (addr[21]) flt_n = 1'b0;
        else ack_n = 1'b0;
      end
      cnt = cnt + 3'h1;
    end
  end
endmodule : cbsc_far
`default_nettype wire

// File: testbench/cbsc_top_bench.sv
// self-checking bench for the bus signal control block
`timescale 1ns/1ps
`default_nettype none
module cbsc_top_bench;
  import cbsc_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, rcmd = 1'b0, stop = 1'b0, rirq = 1'b0, wsel = 1'b1;
  logic        breq_n = 1'b1, gack_n = 1'b1, xhalt_n = 1'b1, xrst_n = 1'b1, npart = 1'b0;
  logic [2:0]  pri_n = 3'h7;
  cbsc_req_s   req = '0;
  cbsc_rsp_s   rsp, got;
  logic [2:0]  lvl, space;
  logic [22:0] addr;
  logic [15:0] din, dout;
  logic        nmi, sysr, wide, astb_n, ustb_n, lstb_n, rnw, boe, doe, ack_n, flt_n, gnt_n, roe, hoe, sel_n;
  int          num_errors = 0, compares = 0, cycles = 0;

  cbsc_top u_dut (
    .MCLK(mclk), .RST_N(rst_n), .REQ(req), .RSP(rsp), .RESET_CMD(rcmd), .STOPPED(stop),
    .NARROW_PART(npart), .REDUCED_IRQ(rirq), .IRQ_LEVEL(lvl), .IRQ_NMI(nmi), .SYS_RESET(sysr),
    .WIDE_BUS(wide), .ADDR(addr), .SPACE_CODE(space), .ADDR_STROBE_N(astb_n),
    .UPPER_BYTE_STROBE_N(ustb_n), .LOWER_BYTE_STROBE_N(lstb_n), .READ_NOT_WRITE(rnw),
    .BUS_OE(boe), .DATA_I(din), .DATA_O(dout), .DATA_OE(doe), .XFER_ACK_N(ack_n),
    .BUS_FAULT_N(flt_n), .BUS_REQUEST_N(breq_n), .BUS_GRANT_N(gnt_n), .GRANT_ACK_N(gack_n),
    .IRQ_PRIORITY_IN(pri_n), .WIDTH_SEL(wsel), .RESET_I(xrst_n & ~roe), .RESET_O(), .RESET_OE(roe),
    .HALT_I(xhalt_n & ~hoe), .HALT_O(), .HALT_OE(hoe), .SLOW_BUS_CLK(),
    .SYNC_PERIPH_SELECT_N(sel_n), .SYNC_ADDR_VALID_N()
  );
  cbsc_far u_far (.clk(mclk), .astb_n(astb_n), .space(space), .addr(addr), .ack_n(ack_n),
    .flt_n(flt_n), .sel_n(sel_n), .dat(din));

  // clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // one bus cycle, held until the block answers
  task automatic xfer(input logic rd, ik, up, lo, input logic [22:0] a, input logic [15:0] wd);
    req = '{1'b1, rd, ik, up, lo, ik ? 3'h7 : 3'h5, a, wd};
    for (int i = 0; i < 300; i++) begin
      tick(1);
      if (rsp.done === 1'b1 || rsp.fault === 1'b1 || rsp.retry === 1'b1 || rsp.autovec === 1'b1) break;
    end
    got = rsp;
    req.valid = 1'b0;
    tick(4);
  endtask : xfer

  task automatic t_data;
    xfer(1'b0, 1'b0, 1'b1, 1'b1, 23'h000013, 16'hBEEF);
    check(got.done, 1'b1);
    xfer(1'b1, 1'b0, 1'b1, 1'b1, 23'h000021, 16'h0000);
    check(got.rdata, 16'h0021 ^ 16'h5A5A);
    xfer(1'b0, 1'b0, 1'b0, 1'b1, 23'h000002, 16'h00C3);
    check(got.done, 1'b1);
    check(dout, 16'hC3C3);
    xfer(1'b1, 1'b0, 1'b1, 1'b0, 23'h000304, 16'h0000);
    check(got.rdata[15:8], 8'h03 ^ 8'h5A);
  endtask : t_data

  task automatic t_sync;
    xfer(1'b1, 1'b1, 1'b0, 1'b1, {20'hFFFFF, 3'h4}, 16'h0000);
    check(got.autovec, 1'b1);
    xfer(1'b1, 1'b0, 1'b1, 1'b1, 23'h400006, 16'h0000);
    check(got.done, 1'b1);
    check(got.rdata, 16'h0006 ^ 16'h5A5A);
  endtask : t_sync

  task automatic t_fault;
    xfer(1'b1, 1'b0, 1'b1, 1'b1, 23'h200001, 16'h0000);
    check(got.fault, 1'b1);
    fork
      xfer(1'b1, 1'b0, 1'b1, 1'b1, 23'h200007, 16'h0000);
      begin tick(3); xhalt_n = 1'b0; end
    join
    check(got.retry, 1'b1);
    check(boe, 1'b0);
    xhalt_n = 1'b1;
    tick(6);
  endtask : t_fault

  task automatic t_arb;
    fork
      xfer(1'b1, 1'b0, 1'b1, 1'b1, 23'h000007, 16'h0000);
      begin tick(2); breq_n = 1'b0; end
    join
    check(got.done, 1'b1);
    for (int i = 0; i < 20 && gnt_n !== 1'b0; i++) tick(1);
    check(gnt_n, 1'b0);
    // acknowledge on a clear bus, request held with it
    for (int i = 0; i < 20 && (astb_n !== 1'b1 || ack_n !== 1'b1); i++) tick(1);
    gack_n = 1'b0;
    tick(4);
    check(boe, 1'b0);
    check(gnt_n, 1'b0);
    gack_n = 1'b1;
    breq_n = 1'b1;
    tick(6);
    check(gnt_n, 1'b1);
  endtask : t_arb

  task automatic t_sys;
    rcmd = 1'b1;
    stop = 1'b1;
    tick(3);
    check(roe, 1'b1);
    check(hoe, 1'b1);
    check(sysr, 1'b0);
    rcmd = 1'b0;
    stop = 1'b0;
    tick(1);
    check(roe, 1'b0);
    check(sysr, 1'b0);
    for (int i = 0; i < 8; i++) begin
      pri_n = ~i[2:0];
      tick(5);
      check(lvl, i[2:0]);
      check(nmi, i == 7);
    end
    rirq = 1'b1;
    pri_n = 3'b110;
    tick(5);
    check(lvl, 3'h5);
    rirq = 1'b0;
    pri_n = 3'h7;
    tick(5);
    xrst_n = 1'b0;
    xhalt_n = 1'b0;
    tick(3);
    check(sysr, 1'b1);
    xrst_n = 1'b1;
    xhalt_n = 1'b1;
    tick(4);
    check(sysr, 1'b0);
    npart = 1'b1;
    tick(1);
    check(wide, 1'b0);
    xfer(1'b1, 1'b0, 1'b1, 1'b0, 23'h000005, 16'h0000);
    check(got.rdata[7:0], 8'h05 ^ 8'h5A);
    npart = 1'b0;
  endtask : t_sys

  task automatic t_narrow;
    wsel = 1'b0;
    rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
    tick(4);
    check(wide, 1'b0);
    xfer(1'b0, 1'b0, 1'b1, 1'b0, 23'h000010, 16'h3300);
    check(got.done, 1'b1);
    check(dout[7:0], 8'h33);
  endtask : t_narrow

  initial begin
    tick(16);
    rst_n = 1'b1;
    tick(4);
    check(wide, 1'b1);
    t_data();
    t_sync();
    t_fault();
    t_arb();
    t_sys();
    t_narrow();
    end_sim();
  end
endmodule : cbsc_top_bench
bind cbsc_top cbsc_top_props u_props (.*);
`default_nettype wire
